// file: rtl/iopr_regs.sv
// Byte-wide register window for four I/O ports and side registers.
// Assumes a synchronous host bus: select, strobes, offset and data per clock.
`timescale 1ns/100ps
module iopr_regs #(
  parameter logic [7:0] WINDOW_BASE = iopr_pkg::WINDOW_BASE_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_low,
  input wire logic [7:0] host_addr_hi,
  input wire logic [7:0] host_addr_lo,
  input wire logic [7:0] host_addr_pg,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire logic [1:0] host_kind,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic [7:0] port_c_out,
  output logic [7:0] port_d_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_d_oe,
  output logic [7:0] port_a_slew,
  output logic [7:0] port_b_slew,
  input wire logic [7:0] cell1_d,
  input wire logic [7:0] cell2_d,
  input wire logic [7:0] cell1_route_a,
  input wire logic [7:0] cell2_route_c,
  input wire logic [7:0] icell_a,
  input wire logic [7:0] icell_b,
  input wire logic [7:0] icell_c,
  input wire logic [7:0] main_prot,
  input wire logic [7:0] sec_prot,
  input wire logic byte_enable_low,
  input wire logic use_byte_enable,
  input wire logic use_address_latch_strobe,
  input wire logic use_logic_clock_in,
  output logic memory_enable,
  output logic logic_clock_sel,
  output logic logic_clock_level,
  output logic [7:0] test_port_enable,
  output logic [7:0] power_cfg_zero,
  output logic [7:0] power_cfg_two,
  output logic [7:0] memory_page_select,
  output logic [7:0] memory_space_map
);
  logic [7:0] a_fn_reg, b_fn_reg;
  logic [7:0] out_reg [4];
  logic [7:0] dir_reg [4];
  logic [7:0] drv_reg [4];
  logic [7:0] mask1_reg, mask2_reg;
  logic [7:0] off;
  logic sel, wr_hit, rd_hit, wr_ok;
  logic [7:0] rd_next;
  logic [15:0] latched;
  logic [7:0] a_addr, b_addr;
  logic [7:0] oe_next [4];
  logic [7:0] drv_next [4];
  iopr_cell_if cif ();

  // ---------------------------------------------------------------
  // Window decode.
  // ---------------------------------------------------------------
  assign sel = ~chip_select_low && (host_addr_hi == WINDOW_BASE);
  assign off = host_addr_lo;
  assign wr_hit = sel && host_wr;
  assign rd_hit = sel && host_rd;
  assign wr_ok = wr_hit && !(byte_enable_low && use_byte_enable);

  function automatic logic [1:0] port_idx(input logic [7:0] o);
    port_idx = {o[4], o[0]};
  endfunction : port_idx

  function automatic logic is_port_reg(input logic [7:0] o,
      input logic [7:0] base_ab, input logic [7:0] base_cd);
    is_port_reg = (o == base_ab) || (o == base_ab + 8'h01) ||
                  (o == base_cd) || (o == base_cd + 8'h01);
  endfunction : is_port_reg

  // ---------------------------------------------------------------
  // Address latch and latched address output.
  // ---------------------------------------------------------------
  iopr_addr_latch u_latch (
    .clk(clk),
    .rst(rst),
    .strobe(use_address_latch_strobe & port_d_in[0]),
    .addr({host_addr_pg, host_addr_lo}),
    .latched(latched)
  );

  always_comb begin
    a_addr = latched[7:0];
    b_addr = latched[7:0];
    case (iopr_pkg::iopr_host_e'(host_kind))
      iopr_pkg::IOPR_HOST_PAGE: begin
        b_addr = latched[15:8];
        a_addr = 8'h00;
      end
      iopr_pkg::IOPR_HOST_NONMUX: a_addr = 8'h00;
      iopr_pkg::IOPR_HOST_XA: begin
        a_addr = {latched[7:4], 4'h0};
        b_addr = {4'h0, latched[11:8]};
      end
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // Port control, mask and side registers.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      a_fn_reg <= iopr_pkg::RESET_BYTE;
      b_fn_reg <= iopr_pkg::RESET_BYTE;
    end else if (wr_ok) begin
      if (off == iopr_pkg::OFF_A_FN) a_fn_reg <= host_wdata;
      if (off == iopr_pkg::OFF_B_FN) b_fn_reg <= host_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        out_reg[i] <= iopr_pkg::RESET_BYTE;
        dir_reg[i] <= iopr_pkg::RESET_BYTE;
        drv_reg[i] <= iopr_pkg::RESET_BYTE;
      end
    end else if (wr_ok) begin
      if (is_port_reg(off, iopr_pkg::OFF_A_OUT, iopr_pkg::OFF_C_OUT)) begin
        out_reg[port_idx(off)] <= host_wdata;
      end
      if (is_port_reg(off, iopr_pkg::OFF_A_DIR, iopr_pkg::OFF_C_DIR)) begin
        dir_reg[port_idx(off)] <= host_wdata;
      end
      if (is_port_reg(off, iopr_pkg::OFF_A_DRV, iopr_pkg::OFF_C_DRV)) begin
        drv_reg[port_idx(off)] <= host_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask1_reg <= iopr_pkg::RESET_BYTE;
      mask2_reg <= iopr_pkg::RESET_BYTE;
      test_port_enable <= iopr_pkg::RESET_BYTE;
      power_cfg_zero <= iopr_pkg::RESET_BYTE;
      power_cfg_two <= iopr_pkg::RESET_BYTE;
      memory_page_select <= iopr_pkg::RESET_BYTE;
      memory_space_map <= iopr_pkg::RESET_BYTE;
    end else if (wr_ok) begin
      case (off)
        iopr_pkg::OFF_MASK1: mask1_reg <= host_wdata;
        iopr_pkg::OFF_MASK2: mask2_reg <= host_wdata;
        iopr_pkg::OFF_TEST_EN: test_port_enable <= host_wdata;
        iopr_pkg::OFF_PWR0: power_cfg_zero <= host_wdata;
        iopr_pkg::OFF_PWR2: power_cfg_two <= host_wdata;
        iopr_pkg::OFF_PAGE: memory_page_select <= host_wdata;
        iopr_pkg::OFF_SPACE_MAP: memory_space_map <= host_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Macrocell bank.
  // ---------------------------------------------------------------
  assign cif.wr = {wr_ok && off == iopr_pkg::OFF_CELL2,
                   wr_ok && off == iopr_pkg::OFF_CELL1};
  assign cif.wdata = host_wdata;

  iopr_cell_bank u_cells (
    .clk(clk),
    .rst(rst),
    .cell1_d(cell1_d),
    .cell2_d(cell2_d),
    .mask1(mask1_reg),
    .mask2(mask2_reg),
    .cif(cif)
  );

  // ---------------------------------------------------------------
  // Pin drive and enable.
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oe_next[i] = dir_reg[i];
      drv_next[i] = out_reg[i];
    end
    oe_next[0] = dir_reg[0] | a_fn_reg | cell1_route_a;
    oe_next[1] = dir_reg[1] | b_fn_reg;
    oe_next[2] = dir_reg[2] | cell2_route_c;
    drv_next[0] = (a_fn_reg & a_addr) | (cell1_route_a & cif.cell1) |
                  (~a_fn_reg & ~cell1_route_a & out_reg[0]);
    drv_next[1] = (b_fn_reg & b_addr) | (~b_fn_reg & out_reg[1]);
    drv_next[2] = (cell2_route_c & cif.cell2) |
                  (~cell2_route_c & out_reg[2]);
    if (use_address_latch_strobe) oe_next[3][0] = 1'b0;
    if (use_logic_clock_in) oe_next[3][1] = 1'b0;
    if (use_byte_enable) oe_next[2][7] = 1'b0;
    for (int i = 0; i < 3; i++) begin
      oe_next[i] = oe_next[i] & ~(drv_reg[i] & drv_next[i] &
        ((i == 2) ? iopr_pkg::OPEN_DRAIN_PINS_C :
        iopr_pkg::OPEN_DRAIN_PINS));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_out <= iopr_pkg::RESET_BYTE;
      port_b_out <= iopr_pkg::RESET_BYTE;
      port_c_out <= iopr_pkg::RESET_BYTE;
      port_d_out <= iopr_pkg::RESET_BYTE;
      port_a_oe <= iopr_pkg::RESET_BYTE;
      port_b_oe <= iopr_pkg::RESET_BYTE;
      port_c_oe <= iopr_pkg::RESET_BYTE;
      port_d_oe <= iopr_pkg::RESET_BYTE;
      port_a_slew <= iopr_pkg::RESET_BYTE;
      port_b_slew <= iopr_pkg::RESET_BYTE;
    end else begin
      port_a_out <= drv_next[0];
      port_b_out <= drv_next[1];
      port_c_out <= drv_next[2];
      port_d_out <= drv_next[3];
      port_a_oe <= oe_next[0];
      port_b_oe <= oe_next[1];
      port_c_oe <= oe_next[2];
      port_d_oe <= oe_next[3];
      port_a_slew <= drv_reg[0] & ~iopr_pkg::OPEN_DRAIN_PINS;
      port_b_slew <= drv_reg[1] & ~iopr_pkg::OPEN_DRAIN_PINS;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      memory_enable <= 1'b0;
      logic_clock_sel <= 1'b0;
      logic_clock_level <= 1'b0;
    end else begin
      memory_enable <= ~chip_select_low ? 1'b1 : 1'b0;
      logic_clock_sel <= use_logic_clock_in;
      logic_clock_level <= use_logic_clock_in & port_d_in[1];
    end
  end

  // ---------------------------------------------------------------
  // Read path.
  // ---------------------------------------------------------------
  always_comb begin
    rd_next = 8'h00;
    case (off)
      iopr_pkg::OFF_A_IN: rd_next = port_a_in;
      iopr_pkg::OFF_B_IN: rd_next = port_b_in;
      iopr_pkg::OFF_C_IN: rd_next = port_c_in;
      iopr_pkg::OFF_D_IN: rd_next = port_d_in;
      iopr_pkg::OFF_A_FN: rd_next = a_fn_reg;
      iopr_pkg::OFF_B_FN: rd_next = b_fn_reg;
      iopr_pkg::OFF_A_OUT: rd_next = out_reg[0];
      iopr_pkg::OFF_B_OUT: rd_next = out_reg[1];
      iopr_pkg::OFF_C_OUT: rd_next = out_reg[2];
      iopr_pkg::OFF_D_OUT: rd_next = out_reg[3];
      iopr_pkg::OFF_A_DIR: rd_next = dir_reg[0];
      iopr_pkg::OFF_B_DIR: rd_next = dir_reg[1];
      iopr_pkg::OFF_C_DIR: rd_next = dir_reg[2];
      iopr_pkg::OFF_D_DIR: rd_next = dir_reg[3];
      iopr_pkg::OFF_A_DRV: rd_next = drv_reg[0];
      iopr_pkg::OFF_B_DRV: rd_next = drv_reg[1];
      iopr_pkg::OFF_C_DRV: rd_next = drv_reg[2];
      iopr_pkg::OFF_D_DRV: rd_next = drv_reg[3];
      iopr_pkg::OFF_A_ICELL: rd_next = icell_a;
      iopr_pkg::OFF_B_ICELL: rd_next = icell_b;
      iopr_pkg::OFF_C_ICELL: rd_next = icell_c;
      iopr_pkg::OFF_A_OE: rd_next = port_a_oe;
      iopr_pkg::OFF_B_OE: rd_next = port_b_oe;
      iopr_pkg::OFF_C_OE: rd_next = port_c_oe;
      iopr_pkg::OFF_D_OE: rd_next = port_d_oe;
      iopr_pkg::OFF_CELL1: rd_next = cif.cell1;
      iopr_pkg::OFF_CELL2: rd_next = cif.cell2;
      iopr_pkg::OFF_MASK1: rd_next = mask1_reg;
      iopr_pkg::OFF_MASK2: rd_next = mask2_reg;
      iopr_pkg::OFF_PWR0: rd_next = power_cfg_zero;
      iopr_pkg::OFF_PWR2: rd_next = power_cfg_two;
      iopr_pkg::OFF_MAIN_PROT: rd_next = main_prot;
      iopr_pkg::OFF_SEC_PROT: rd_next = sec_prot;
      iopr_pkg::OFF_TEST_EN: rd_next = test_port_enable;
      iopr_pkg::OFF_PAGE: rd_next = memory_page_select;
      iopr_pkg::OFF_SPACE_MAP: rd_next = memory_space_map;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= rd_hit;
      if (rd_hit) host_rdata <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  property p_pin_read;
    @(posedge clk) disable iff (rst)
    rd_hit && off == iopr_pkg::OFF_A_IN |=> host_rdata == $past(port_a_in);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("Port A pin read wrong.");

  property p_out_store;
    @(posedge clk) disable iff (rst)
    wr_ok && off == iopr_pkg::OFF_C_OUT |=> out_reg[2] == $past(host_wdata);
  endproperty
  a_out_store: assert property (p_out_store)
    else $error("Port C output value not stored.");

  property p_dir_oe;
    @(posedge clk) disable iff (rst)
    !use_address_latch_strobe && !use_logic_clock_in ##1 1'b1
      |-> port_d_oe == $past(dir_reg[3]);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("Port D enable does not follow direction.");

  property p_oe_read;
    @(posedge clk) disable iff (rst)
    rd_hit && off == iopr_pkg::OFF_B_OE |=> host_rdata == $past(port_b_oe);
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("Enable readback wrong.");

  property p_prot_ro;
    @(posedge clk) disable iff (rst)
    rd_hit && off == iopr_pkg::OFF_MAIN_PROT |=> host_rdata == $past(main_prot);
  endproperty
  a_prot_ro: assert property (p_prot_ro)
    else $error("Protection status read wrong.");

  property p_sec_ro;
    @(posedge clk) disable iff (rst)
    rd_hit && off == iopr_pkg::OFF_SEC_PROT |=> host_rdata == $past(sec_prot);
  endproperty
  a_sec_ro: assert property (p_sec_ro)
    else $error("Security status read wrong.");

  property p_mem_en;
    @(posedge clk) disable iff (rst)
    chip_select_low |=> !memory_enable;
  endproperty
  a_mem_en: assert property (p_mem_en)
    else $error("Memory enabled while deselected.");

  property p_page_addr;
    @(posedge clk) disable iff (rst)
    host_kind == 2'h2 && b_fn_reg == 8'hFF && $stable(latched)
      |=> port_b_out == $past(latched[15:8]);
  endproperty
  a_page_addr: assert property (p_page_addr)
    else $error("Page mode address output wrong.");

  property p_unmapped;
    @(posedge clk) disable iff (rst)
    rd_hit && off == 8'hFF |=> host_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped read not zero.");
endmodule : iopr_regs

// file: include/iopr_pkg.sv
// Constants and types for the I/O port register window.
// Assumes a byte-wide host bus with one clock and a synchronous reset.
//
// Functional notes
// - Decode a 256-byte window placed by the user; offset picks the register.
// - Data-in read returns present pin levels of that port.
// - Ports A and B control register picks host I/O or latched address.
// - Data-out write stores value; driven on pins in host output mode.
// - Direction register sets each pin as input or output.
// - Drive-select picks open-drain on capable pins of ports A, B and C, high slew on the other pins of A and B; port D drive-select drives nothing.
// - Output-enable readback returns actual driver enable from any source.
// - Macrocell group register reads cell outputs, write loads cell flops.
// - Mask register blocks host writes to covered macrocells.
// - Main sector protection status is read only; writes ignored.
// - Security and boot sector protection status is read only.
// - Memory-space map places each memory area in program or data space.
// - Chip select low reaches memory and I/O; high disables memories.
// - Address strobe on port D bit 0 latches the host address.
// - Port D bit 1 can act as clock for the logic cells.
// - Multiplexed hosts: address [3:0] low nibble, [7:4] high nibble.
// - Page mode: port B gets address [11:8] low and [15:12] high.
package iopr_pkg;
  localparam logic [7:0] OFF_A_IN = 8'h00;
  localparam logic [7:0] OFF_B_IN = 8'h01;
  localparam logic [7:0] OFF_A_FN = 8'h02;
  localparam logic [7:0] OFF_B_FN = 8'h03;
  localparam logic [7:0] OFF_A_OUT = 8'h04;
  localparam logic [7:0] OFF_B_OUT = 8'h05;
  localparam logic [7:0] OFF_A_DIR = 8'h06;
  localparam logic [7:0] OFF_B_DIR = 8'h07;
  localparam logic [7:0] OFF_A_DRV = 8'h08;
  localparam logic [7:0] OFF_B_DRV = 8'h09;
  localparam logic [7:0] OFF_A_ICELL = 8'h0A;
  localparam logic [7:0] OFF_B_ICELL = 8'h0B;
  localparam logic [7:0] OFF_A_OE = 8'h0C;
  localparam logic [7:0] OFF_B_OE = 8'h0D;
  localparam logic [7:0] OFF_C_IN = 8'h10;
  localparam logic [7:0] OFF_D_IN = 8'h11;
  localparam logic [7:0] OFF_C_OUT = 8'h12;
  localparam logic [7:0] OFF_D_OUT = 8'h13;
  localparam logic [7:0] OFF_C_DIR = 8'h14;
  localparam logic [7:0] OFF_D_DIR = 8'h15;
  localparam logic [7:0] OFF_C_DRV = 8'h16;
  localparam logic [7:0] OFF_D_DRV = 8'h17;
  localparam logic [7:0] OFF_C_ICELL = 8'h18;
  localparam logic [7:0] OFF_C_OE = 8'h1A;
  localparam logic [7:0] OFF_D_OE = 8'h1B;
  localparam logic [7:0] OFF_CELL1 = 8'h20;
  localparam logic [7:0] OFF_CELL2 = 8'h21;
  localparam logic [7:0] OFF_MASK1 = 8'h22;
  localparam logic [7:0] OFF_MASK2 = 8'h23;
  localparam logic [7:0] OFF_PWR0 = 8'hB0;
  localparam logic [7:0] OFF_PWR2 = 8'hB4;
  localparam logic [7:0] OFF_MAIN_PROT = 8'hC0;
  localparam logic [7:0] OFF_SEC_PROT = 8'hC2;
  localparam logic [7:0] OFF_TEST_EN = 8'hC7;
  localparam logic [7:0] OFF_PAGE = 8'hE0;
  localparam logic [7:0] OFF_SPACE_MAP = 8'hE2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] WINDOW_BASE_DEF = 8'h00;
  localparam logic [7:0] OPEN_DRAIN_PINS = 8'hF0;
  localparam logic [7:0] OPEN_DRAIN_PINS_C = 8'hFF;
  localparam int READ_LATENCY = 1;
  typedef enum logic [1:0] {
    IOPR_HOST_MUX, IOPR_HOST_NONMUX, IOPR_HOST_PAGE, IOPR_HOST_XA
  } iopr_host_e;
endpackage : iopr_pkg

// file: include/iopr_cell_if.sv
// Interface carrying macrocell group load requests to the cell bank.
// Assumes both ends run on the block clock.
`timescale 1ns/100ps
interface iopr_cell_if;
  logic [1:0] wr;
  logic [7:0] wdata;
  logic [7:0] cell1;
  logic [7:0] cell2;
  modport ctrl (output wr, output wdata, input cell1, input cell2);
  modport bank (input wr, input wdata, output cell1, output cell2);
endinterface : iopr_cell_if

// file: rtl/iopr_cell_bank.sv
// Macrocell flip-flops with host load masks.
// Assumes logic feeds next values through cell_d each cycle.
`timescale 1ns/100ps
module iopr_cell_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cell1_d,
  input wire logic [7:0] cell2_d,
  input wire logic [7:0] mask1,
  input wire logic [7:0] mask2,
  iopr_cell_if.bank cif
);
  logic [7:0] cell1_reg;
  logic [7:0] cell2_reg;

  function automatic logic [7:0] masked_load(input logic [7:0] cur,
      input logic [7:0] wd, input logic [7:0] msk);
    masked_load = (cur & msk) | (wd & ~msk);
  endfunction : masked_load

  always_ff @(posedge clk) begin
    if (rst) begin
      cell1_reg <= iopr_pkg::RESET_BYTE;
      cell2_reg <= iopr_pkg::RESET_BYTE;
    end else begin
      if (cif.wr[0]) begin
        cell1_reg <= masked_load(cell1_reg, cif.wdata, mask1);
      end else begin
        cell1_reg <= cell1_d;
      end
      if (cif.wr[1]) begin
        cell2_reg <= masked_load(cell2_reg, cif.wdata, mask2);
      end else begin
        cell2_reg <= cell2_d;
      end
    end
  end

  assign cif.cell1 = cell1_reg;
  assign cif.cell2 = cell2_reg;

  property p_mask_holds;
    @(posedge clk) disable iff (rst)
    cif.wr[0] |=> ((cell1_reg & $past(mask1)) ==
                   ($past(cell1_reg) & $past(mask1)));
  endproperty
  a_mask_holds: assert property (p_mask_holds)
    else $error("Masked cell changed on host write.");
endmodule : iopr_cell_bank

// file: rtl/iopr_addr_latch.sv
// Address latch driven by the host address strobe.
// Assumes strobe and address are synchronous to the clock.
`timescale 1ns/100ps
module iopr_addr_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [15:0] addr,
  output logic [15:0] latched
);
  always_ff @(posedge clk) begin
    if (rst) begin
      latched <= 16'h0000;
    end else if (strobe) begin
      latched <= addr;
    end
  end

  property p_latch;
    @(posedge clk) disable iff (rst) strobe |=> latched == $past(addr);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Address not latched on strobe.");
endmodule : iopr_addr_latch

// file: verification/iopr_host_model.sv
// Host bus model: byte writes and reads into the register window.
// Assumes the bench clock; drives on the falling edge.
`timescale 1ns/100ps
module iopr_host_model (
  input wire logic clk,
  output logic cs_low,
  output logic [7:0] hi,
  output logic [7:0] lo,
  output logic rd,
  output logic wr,
  output logic [7:0] wd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    cs_low = 1'b0;
    hi = 8'h00;
    lo = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 8'h00;
  end
  // Write one byte; the data lines flip once released.
  task automatic put(input logic [7:0] h, input logic [7:0] a,
      input logic [7:0] d);
    @(negedge clk);
    hi = h;
    lo = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    hi = 8'h00;
    wd = ~d;
  endtask : put
  // Drive the chip-select input level.
  task automatic set_cs(input logic v);
    cs_low = v;
  endtask : set_cs
  // Write one byte, then read the same offset in the very next cycle.
  task automatic put_get(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge clk);
    lo = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    q = rdata;
  endtask : put_get
  // Read one byte; waits a bounded time for the valid pulse.
  task automatic get(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    lo = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk);
    q = rdata;
  endtask : get
endmodule : iopr_host_model

// file: verification/testbench.sv
// Self-checking bench for the I/O port register window.
// Assumes iopr_regs at its default base and the host model.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] host_kind = 2'h0;
  logic [7:0] port_a_in, port_b_in, port_c_in, port_d_in, icell_a;
  logic [7:0] icell_b, icell_c, main_prot, sec_prot, cell1_d, cell2_d;
  logic [7:0] host_addr_pg = 8'hAB;
  logic byte_enable_low = 1'b0;
  logic use_byte_enable = 1'b0;
  logic use_address_latch_strobe = 1'b0;
  logic use_logic_clock_in = 1'b0;
  logic [7:0] port_a_out, port_b_out, port_a_oe, port_a_slew, host_rdata;
  logic host_rvalid, memory_enable, logic_clock_sel, logic_clock_level;
  logic chip_select_low, host_rd, host_wr;
  logic [7:0] port_c_out, port_d_out, port_b_oe, port_c_oe, port_d_oe;
  logic [7:0] port_b_slew, test_port_enable, power_cfg_zero, power_cfg_two;
  logic [7:0] memory_page_select, memory_space_map, eb;
  logic [7:0] cell_route = 8'h00;
  logic [7:0] host_addr_hi, host_addr_lo, host_wdata, q;
  logic [7:0] d [19];
  logic [31:0] seed = 32'h025213E0;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [7:0] RO [10] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h0A,
      8'h0B, 8'h18, 8'hC0, 8'hC2, 8'hFF};
  localparam logic [7:0] RW [19] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h07, 8'h08, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
      8'hB0, 8'hB4, 8'hC7, 8'hE0, 8'hE2};
  always #4 clk = ~clk;
  iopr_host_model host (.clk, .cs_low(chip_select_low), .hi(host_addr_hi),
      .lo(host_addr_lo), .rd(host_rd), .wr(host_wr), .wd(host_wdata),
      .rdata(host_rdata), .rvalid(host_rvalid));
  iopr_regs uut (.clk, .rst, .chip_select_low, .host_addr_hi,
      .host_addr_lo, .host_addr_pg, .host_rd, .host_wr, .host_wdata,
      .host_rdata, .host_rvalid, .host_kind, .port_a_in, .port_b_in,
      .port_c_in, .port_d_in, .port_a_out, .port_b_out, .port_c_out,
      .port_d_out, .port_a_oe, .port_b_oe, .port_c_oe, .port_d_oe,
      .port_a_slew, .port_b_slew, .cell1_d, .cell2_d,
      .cell1_route_a(cell_route), .cell2_route_c(cell_route), .icell_a,
      .icell_b, .icell_c, .main_prot, .sec_prot, .byte_enable_low,
      .use_byte_enable, .use_address_latch_strobe, .use_logic_clock_in,
      .memory_enable, .logic_clock_sel, .logic_clock_level,
      .test_port_enable, .power_cfg_zero, .power_cfg_two,
      .memory_page_select, .memory_space_map);
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs
  function automatic logic [7:0] ro_exp(input int i);
    logic [7:0] v [10];
    v = '{port_a_in, port_b_in, port_c_in, port_d_in, icell_a, icell_b,
        icell_c, main_prot, sec_prot, 8'h00};
    return v[i];
  endfunction : ro_exp
  function automatic logic [7:0] exp_oe(input logic [7:0] dir,
      input logic [7:0] out, input logic [7:0] drv);
    return dir & ~(out & drv & iopr_pkg::OPEN_DRAIN_PINS);
  endfunction : exp_oe
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d of %0d compares", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask : settle
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {port_a_in, port_b_in, port_c_in} = {xs(), xs(), xs()};
    {icell_a, icell_b, icell_c} = {xs(), xs(), xs()};
    {main_prot, sec_prot, cell1_d, cell2_d} = {xs(), xs(), 16'h3C5A};
    port_d_in = xs() & 8'hFC;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk(port_a_out, 8'h00);
    host.get(8'h04, q);
    chk(q, 8'h00);
    chk({7'h00, host_rvalid}, 8'h01);
    chk({7'h00, memory_enable}, 8'h01);
    for (int i = 0; i < 10; i++) begin
      host.put(8'h00, RO[i], 8'hA5);
      host.get(RO[i], q);
      chk(q, ro_exp(i));
    end
    foreach (d[i]) begin
      d[i] = xs();
      host.put(8'h00, RW[i], d[i]);
    end
    foreach (d[i]) begin
      host.get(RW[i], q);
      chk(q, d[i]);
    end
    chk(port_c_out, d[8]);
    chk(port_c_oe, d[10] & ~(d[8] & d[12]));
    chk(port_d_out, d[9]);
    chk(port_d_oe, d[11]);
    chk(port_b_slew, d[7] & 8'h0F);
    chk(power_cfg_zero, d[14]);
    chk(power_cfg_two, d[15]);
    chk(test_port_enable, d[16]);
    chk(memory_page_select, d[17]);
    chk(memory_space_map, d[18]);
    host.put(8'h01, 8'h04, 8'h77);
    host.set_cs(1'b1);
    host.put(8'h00, 8'h04, 8'h11);
    chk({7'h00, memory_enable}, 8'h00);
    host.set_cs(1'b0);
    {use_byte_enable, byte_enable_low} = 2'b11;
    host.put(8'h00, 8'h04, 8'h22);
    host.get(8'h04, q);
    chk(q, d[2]);
    {use_byte_enable, byte_enable_low} = 2'b00;
    host.put(8'h00, 8'h02, 8'h00);
    host.put(8'h00, 8'h06, 8'hFF);
    host.put(8'h00, 8'h08, 8'hFF);
    host.put(8'h00, 8'h04, 8'hA5);
    settle();
    chk(port_a_out, 8'hA5);
    chk(port_a_oe, exp_oe(8'hFF, 8'hA5, 8'hFF));
    chk(port_a_slew, 8'h0F);
    host.get(8'h0C, q);
    chk(q, exp_oe(8'hFF, 8'hA5, 8'hFF));
    cell_route = 8'hF0;
    host.put(8'h00, 8'h06, 8'h00);
    settle();
    chk(port_a_out, (cell1_d & 8'hF0) | 8'h05);
    host.get(8'h0C, q);
    chk(q, exp_oe(8'hF0, (cell1_d & 8'hF0) | 8'h05, 8'hFF));
    cell_route = 8'h00;
    use_address_latch_strobe = 1'b1;
    port_d_in[0] = 1'b1;
    host.get(8'hCD, q);
    port_d_in[0] = 1'b0;
    host.put(8'h00, 8'h02, 8'hFF);
    host.put(8'h00, 8'h03, 8'hFF);
    host.put(8'h00, 8'h07, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      host_kind = k[1:0];
      eb = (k == 2) ? 8'hAB : (k == 3) ? 8'h0B : 8'hCD;
      settle();
      chk(port_b_out, eb);
      chk(port_b_oe, exp_oe(8'hFF, eb, d[7]));
      chk(port_a_out, (k == 0) ? 8'hCD : (k == 3) ? 8'hC0 : 8'h00);
    end
    host.put(8'h00, 8'h22, 8'hFF);
    host.put_get(8'h20, 8'h00, q);
    chk(q, 8'h3C);
    host.put(8'h00, 8'h22, 8'h0F);
    host.put_get(8'h20, 8'hA5, q);
    chk(q, (cell1_d & 8'h0F) | (8'hA5 & 8'hF0));
    host.put_get(8'h21, 8'h96, q);
    chk(q, 8'h96);
    host.get(8'h21, q);
    chk(q, 8'h5A);
    use_logic_clock_in = 1'b1;
    port_d_in[1] = 1'b1;
    settle();
    chk({6'h00, logic_clock_sel, logic_clock_level}, 8'h03);
    port_d_in[1] = 1'b0;
    settle();
    chk({7'h00, logic_clock_level}, 8'h00);
    close_out();
  end
endmodule : testbench
